// ==== common/dpcd_pkg.sv ====
// Constants and types shared by the printer command decoder
`default_nettype none
package dpcd_pkg;
	// Clock rate, cover restart delay, sensor count and buffer width
	localparam int DPCD_CLK_KHZ = 50_000;
	localparam int DPCD_COVER_MS = 3000;
	localparam int DPCD_COVER_CYCLES = DPCD_COVER_MS * DPCD_CLK_KHZ;
	localparam int DPCD_DOC_SENSORS = 4;
	localparam int DPCD_BUF_WIDTH = 8;

	// Control codes
	localparam logic [7:0] DPCD_B_STAT_NOW = 8'h05;
	localparam logic [7:0] DPCD_B_UPPER_NOW = 8'h07;
	localparam logic [7:0] DPCD_B_BACK = 8'h08;
	localparam logic [7:0] DPCD_B_TAB = 8'h09;
	localparam logic [7:0] DPCD_B_LINE = 8'h0A;
	localparam logic [7:0] DPCD_B_VERT = 8'h0B;
	localparam logic [7:0] DPCD_B_EJECT = 8'h0C;
	localparam logic [7:0] DPCD_B_PRINT = 8'h0D;
	localparam logic [7:0] DPCD_B_EXP_ON = 8'h0E;
	localparam logic [7:0] DPCD_B_EXP_OFF = 8'h0F;
	localparam logic [7:0] DPCD_B_KEY_A = 8'h11;
	localparam logic [7:0] DPCD_B_KEY_B = 8'h10;
	localparam logic [7:0] DPCD_B_LCOUNT = 8'h12;
	localparam logic [7:0] DPCD_B_UPPER_A = 8'h13;
	localparam logic [7:0] DPCD_B_UPPER_B = 8'h17;
	localparam logic [7:0] DPCD_B_MRESET = 8'h14;
	localparam logic [7:0] DPCD_B_CLEAR = 8'h18;
	localparam logic [7:0] DPCD_B_DOCLEN = 8'h19;
	localparam logic [7:0] DPCD_B_STAT_DLY = 8'h1A;
	localparam logic [7:0] DPCD_B_ESCAPE = 8'h1B;
	localparam logic [7:0] DPCD_B_LOWER_NOW = 8'h1C;
	localparam logic [7:0] DPCD_B_LOWER_DLY = 8'h1D;
	localparam logic [7:0] DPCD_B_SPACES = 8'h1E;
	// Second and third bytes of escape sequences
	localparam logic [7:0] DPCD_E_SELECT = 8'h7E;
	localparam logic [7:0] DPCD_E_SEL_LEGACY = 8'h43;
	localparam logic [7:0] DPCD_E_SEL_COMPAT = 8'h49;
	localparam logic [7:0] DPCD_E_FEED216 = 8'h4A;
	localparam logic [3:0] DPCD_E_FEED120_HI = 4'h3;

	typedef enum logic {
		DPCD_SET_LEGACY = 1'b0,
		DPCD_SET_COMPAT = 1'b1
	} dpcd_set_t;
	localparam dpcd_set_t DPCD_RESET_SET = DPCD_SET_LEGACY;

	// Gray coded along idle, escape, select, argument
	typedef enum logic [1:0] {
		DPCD_ST_IDLE = 2'h0,
		DPCD_ST_ESC = 2'h1,
		DPCD_ST_SEL = 2'h3,
		DPCD_ST_ARG = 2'h2
	} dpcd_state_t;

	typedef enum logic [4:0] {
		DPCD_A_NONE, DPCD_A_CHAR, DPCD_A_STAT_NOW, DPCD_A_STAT_DLY,
		DPCD_A_UPPER_NOW, DPCD_A_UPPER_DLY, DPCD_A_LOWER_NOW,
		DPCD_A_LOWER_DLY, DPCD_A_REV_LINE, DPCD_A_BACKSPACE,
		DPCD_A_CFG_LOAD, DPCD_A_HTAB, DPCD_A_VFEED, DPCD_A_VTAB,
		DPCD_A_EXP_OFF, DPCD_A_CPI17, DPCD_A_LCOUNT, DPCD_A_CPI10,
		DPCD_A_MRESET, DPCD_A_KEYBUF, DPCD_A_CLEAR, DPCD_A_DOCLEN,
		DPCD_A_FEED120, DPCD_A_FEED216, DPCD_A_SPACES, DPCD_A_SEL_LEGACY,
		DPCD_A_SEL_COMPAT, DPCD_A_LINE, DPCD_A_EJECT, DPCD_A_PRINT,
		DPCD_A_EXP_ON, DPCD_A_ESC_OTHER
	} dpcd_act_t;
endpackage
`default_nettype wire

// ==== common/dpcd_stream_if.sv ====
// Byte stream between the input buffer and the decoder
`timescale 1ns/1ns
`default_nettype none
interface dpcd_stream_if #(parameter int WIDTH = 8);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;
	modport source (output valid, output data, input ready);
	modport sink (input valid, input data, output ready);
endinterface
`default_nettype wire

// ==== rtl/dpcd_buf.sv ====
// Two-entry byte buffer in front of the decoder
`timescale 1ns/1ns
`default_nettype none
module dpcd_buf import dpcd_pkg::*; #(
	parameter int WIDTH = DPCD_BUF_WIDTH
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	dpcd_stream_if.source out
);
	logic [WIDTH-1:0] slot_reg [2];
	logic [1:0] cnt_reg, cnt_next;
	logic rd_reg, wr_reg, ready_reg;
	wire push = in_valid && ready_reg;
	wire pop = out.valid && out.ready;

	// Count moves by one per push or pop, both leave it alone
	assign cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
	assign in_ready = ready_reg;
	assign out.valid = (cnt_reg != 2'h0);
	assign out.data = slot_reg[rd_reg];

	// Ready is registered so the top sees it straight from a flop
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cnt_reg <= 2'h0;
			rd_reg <= 1'b0;
			wr_reg <= 1'b0;
			ready_reg <= 1'b1;
		end else begin
			cnt_reg <= cnt_next;
			rd_reg <= rd_reg ^ pop;
			wr_reg <= wr_reg ^ push;
			ready_reg <= (cnt_next != 2'h2);
		end
	end

	always_ff @(posedge clock) begin
		if (push) begin
			slot_reg[wr_reg] <= in_data;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	a_buf_no_over: assert property (cnt_reg == 2'h2 |-> !in_ready)
		else $error("buffer accepts while full");
	a_buf_hold_out: assert property (out.valid && !out.ready |=>
		out.valid && $stable(out.data))
		else $error("buffer head changed while stalled");
	c_buf_full: cover property (cnt_reg == 2'h2);
endmodule // dpcd_buf
`default_nettype wire

// ==== rtl/dpcd_guard.sv ====
// Cover, page overflow and eject jam fault tracking
`timescale 1ns/1ns
`default_nettype none
module dpcd_guard import dpcd_pkg::*; #(
	parameter int HOLD_CYCLES = DPCD_COVER_CYCLES,
	parameter int SENSORS = DPCD_DOC_SENSORS
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic cabinet_open,
	input wire logic [SENSORS-1:0] doc_covered,
	input wire logic doc_inserted,
	input wire logic at_last_line,
	input wire logic feed_evt,
	input wire logic eject_done,
	input wire logic jam_clear,
	output logic print_en,
	output logic page_overflow,
	output logic eject_jam,
	output logic eject_req,
	output logic cover_hold
);
	localparam int CW = $clog2(HOLD_CYCLES + 1);
	logic [CW-1:0] cnt_reg, cnt_next;
	logic ovf_reg, ovf_next, jam_reg, jam_next, pwr_reg;
	logic pen_reg, ejr_reg, hold_reg;
	wire any_cov = |doc_covered;
	wire ovf_set = feed_evt && at_last_line;
	wire jam_set = (eject_done || pwr_reg) && any_cov;

	// Reload while open, count down once closed
	assign cnt_next = cabinet_open ? CW'(HOLD_CYCLES) :
		(cnt_reg != '0) ? cnt_reg - CW'(1) : cnt_reg;
	// Set beats the clear in the same cycle
	assign ovf_next = ovf_set || (ovf_reg && !doc_inserted);
	assign jam_next = jam_set || (jam_reg && !jam_clear);
	assign print_en = pen_reg;
	assign page_overflow = ovf_reg;
	assign eject_jam = jam_reg;
	assign eject_req = ejr_reg;
	assign cover_hold = hold_reg;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cnt_reg <= '0;
			ovf_reg <= 1'b0;
			jam_reg <= 1'b0;
			pwr_reg <= 1'b1;
			pen_reg <= 1'b0;
			ejr_reg <= 1'b0;
			hold_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			ovf_reg <= ovf_next;
			jam_reg <= jam_next;
			pwr_reg <= 1'b0;
			ejr_reg <= ovf_set;
			hold_reg <= cabinet_open || (cnt_next != '0);
			pen_reg <= !cabinet_open && (cnt_next == '0) &&
				!ovf_next && !jam_next;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	a_cover_stops_print: assert property (
		cabinet_open |=> !print_en)
		else $error("printing enabled with cabinet open");
	a_cover_hold_time: assert property ($fell(cabinet_open) |->
		!print_en [*2]) else $error("printing resumed too early");
	a_overflow_eject: assert property (ovf_set |=> page_overflow &&
		eject_req ##1 !eject_req)
		else $error("overflow did not eject once");
	a_overflow_hold: assert property (
		page_overflow && !doc_inserted |=> page_overflow && !print_en)
		else $error("overflow released without document");
	a_jam_on_eject: assert property (
		eject_done && any_cov |=> eject_jam)
		else $error("eject jam not flagged");
	c_cover_cycle: cover property ($fell(cabinet_open) ##1 cover_hold);
endmodule // dpcd_guard
`default_nettype wire

// ==== rtl/dpcd_decoder.sv ====
// Printer command decoder: byte stream in, classified actions out
`timescale 1ns/1ns
`default_nettype none
module dpcd_decoder import dpcd_pkg::*; #(
	parameter int COVER_HOLD_CYCLES = DPCD_COVER_CYCLES,
	parameter int SENSORS = DPCD_DOC_SENSORS
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [7:0] in_data,
	input wire logic keypad_sel,
	input wire logic keypad_compat,
	output logic act_valid,
	input wire logic act_ready,
	output dpcd_act_t act_code,
	output logic [7:0] act_arg,
	output dpcd_set_t cmd_set,
	input wire logic cabinet_open,
	input wire logic [SENSORS-1:0] doc_covered,
	input wire logic doc_inserted,
	input wire logic at_last_line,
	input wire logic eject_done,
	input wire logic jam_clear,
	output logic print_en,
	output logic page_overflow,
	output logic eject_jam,
	output logic eject_req,
	output logic cover_hold
);
	// Legacy requests reachable in both sets
	function automatic dpcd_act_t legacy_req(input logic [7:0] b);
		dpcd_act_t a;
		a = DPCD_A_NONE;
		unique case (b)
			DPCD_B_STAT_NOW: a = DPCD_A_STAT_NOW;
			DPCD_B_STAT_DLY: a = DPCD_A_STAT_DLY;
			DPCD_B_UPPER_NOW: a = DPCD_A_UPPER_NOW;
			DPCD_B_UPPER_A, DPCD_B_UPPER_B: a = DPCD_A_UPPER_DLY;
			DPCD_B_LOWER_NOW: a = DPCD_A_LOWER_NOW;
			DPCD_B_LOWER_DLY: a = DPCD_A_LOWER_DLY;
			DPCD_B_KEY_A, DPCD_B_KEY_B: a = DPCD_A_KEYBUF;
			default: a = DPCD_A_NONE;
		endcase
		return a;
	endfunction

	// Single control byte under the active set
	function automatic dpcd_act_t ctrl_act(input logic [7:0] b,
		input dpcd_set_t s);
		dpcd_act_t a;
		logic cp;
		cp = (s == DPCD_SET_COMPAT);
		a = DPCD_A_CHAR;
		unique case (b)
			DPCD_B_BACK: a = cp ? DPCD_A_BACKSPACE : DPCD_A_REV_LINE;
			DPCD_B_TAB: a = cp ? DPCD_A_HTAB : DPCD_A_CFG_LOAD;
			DPCD_B_LINE: a = DPCD_A_LINE;
			DPCD_B_VERT: a = cp ? DPCD_A_VTAB : DPCD_A_VFEED;
			DPCD_B_EJECT: a = DPCD_A_EJECT;
			DPCD_B_PRINT: a = DPCD_A_PRINT;
			DPCD_B_EXP_ON: a = DPCD_A_EXP_ON;
			DPCD_B_EXP_OFF: a = cp ? DPCD_A_CPI17 : DPCD_A_EXP_OFF;
			DPCD_B_LCOUNT: a = cp ? DPCD_A_CPI10 : DPCD_A_LCOUNT;
			DPCD_B_MRESET: a = cp ? DPCD_A_EXP_OFF : DPCD_A_MRESET;
			DPCD_B_CLEAR: a = cp ? DPCD_A_CLEAR : DPCD_A_CHAR;
			DPCD_B_DOCLEN: a = cp ? DPCD_A_CHAR : DPCD_A_DOCLEN;
			DPCD_B_SPACES: a = cp ? DPCD_A_CHAR : DPCD_A_SPACES;
			DPCD_B_ESCAPE: a = DPCD_A_NONE;
			default: a = DPCD_A_CHAR;
		endcase
		// Bare request codes only act in the legacy set
		if (!cp && legacy_req(b) != DPCD_A_NONE) begin
			a = legacy_req(b);
		end
		return a;
	endfunction

	function automatic logic takes_arg(input dpcd_act_t a);
		return a == DPCD_A_CFG_LOAD || a == DPCD_A_VFEED ||
			a == DPCD_A_SPACES || a == DPCD_A_FEED216;
	endfunction

	function automatic logic is_feed(input dpcd_act_t a);
		return a == DPCD_A_LINE || a == DPCD_A_REV_LINE ||
			a == DPCD_A_VFEED || a == DPCD_A_FEED120 ||
			a == DPCD_A_FEED216 || a == DPCD_A_VTAB;
	endfunction

	dpcd_stream_if #(.WIDTH(8)) strm ();
	dpcd_state_t st_reg, st_next;
	dpcd_set_t set_reg, set_next;
	dpcd_act_t pend_reg, pend_next, out_act;
	logic av_reg;
	dpcd_act_t ac_reg;
	logic [7:0] aa_reg, out_arg;
	logic emit;

	// Bytes queue here so a stalled consumer drops nothing
	dpcd_buf #(.WIDTH(8)) u_buf (
		.clock(clock),
		.rst(rst),
		.in_valid(in_valid),
		.in_ready(in_ready),
		.in_data(in_data),
		.out(strm.source)
	);

	wire [7:0] b = strm.data;
	wire dpcd_act_t ctl = ctrl_act(b, set_reg);
	wire dpcd_act_t lreq = legacy_req(b);
	wire slot_free = !av_reg || act_ready;
	// Printing bytes wait while a fault or the cover holds printing
	wire print_blk = !print_en && st_reg == DPCD_ST_IDLE &&
		(ctl == DPCD_A_CHAR || ctl == DPCD_A_PRINT);
	wire take = strm.valid && slot_free && !print_blk;
	wire fire = av_reg && act_ready;
	wire hi3 = (b[7:4] == DPCD_E_FEED120_HI);
	assign strm.ready = slot_free && !print_blk;

	// Sequence walker: escape prefix, set select and argument bytes
	always_comb begin
		st_next = st_reg;
		set_next = set_reg;
		pend_next = pend_reg;
		out_act = DPCD_A_NONE;
		out_arg = b;
		emit = 1'b0;
		if (keypad_sel) begin
			set_next = keypad_compat ? DPCD_SET_COMPAT :
				DPCD_SET_LEGACY;
		end
		if (take) begin
			unique case (st_reg)
				DPCD_ST_IDLE: begin
					if (b == DPCD_B_ESCAPE) begin
						st_next = DPCD_ST_ESC;
					end else if (takes_arg(ctl)) begin
						pend_next = ctl;
						st_next = DPCD_ST_ARG;
					end else begin
						out_act = ctl;
						emit = 1'b1;
					end
				end
				DPCD_ST_ESC: begin
					st_next = DPCD_ST_IDLE;
					emit = 1'b1;
					if (b == DPCD_E_SELECT) begin
						st_next = DPCD_ST_SEL;
						emit = 1'b0;
					end else if (b == DPCD_E_FEED216) begin
						pend_next = DPCD_A_FEED216;
						st_next = DPCD_ST_ARG;
						emit = 1'b0;
					end else if (set_reg == DPCD_SET_LEGACY && hi3) begin
						out_act = DPCD_A_FEED120;
						out_arg = {4'h0, b[3:0]};
					end else if (set_reg == DPCD_SET_COMPAT &&
						lreq != DPCD_A_NONE) begin
						out_act = lreq;
					end else begin
						out_act = DPCD_A_ESC_OTHER;
					end
				end
				DPCD_ST_SEL: begin
					st_next = DPCD_ST_IDLE;
					emit = 1'b1;
					out_act = DPCD_A_ESC_OTHER;
					if (b == DPCD_E_SEL_LEGACY) begin
						set_next = DPCD_SET_LEGACY;
						out_act = DPCD_A_SEL_LEGACY;
					end else if (b == DPCD_E_SEL_COMPAT) begin
						set_next = DPCD_SET_COMPAT;
						out_act = DPCD_A_SEL_COMPAT;
					end
				end
				DPCD_ST_ARG: begin
					out_act = pend_reg;
					emit = 1'b1;
					st_next = DPCD_ST_IDLE;
				end
			endcase
		end
	end

	// State and the one-deep action register
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st_reg <= DPCD_ST_IDLE;
			set_reg <= DPCD_RESET_SET;
			pend_reg <= DPCD_A_NONE;
			av_reg <= 1'b0;
			ac_reg <= DPCD_A_NONE;
			aa_reg <= 8'h00;
		end else begin
			st_reg <= st_next;
			set_reg <= set_next;
			pend_reg <= pend_next;
			if (emit) begin
				av_reg <= 1'b1;
				ac_reg <= out_act;
				aa_reg <= out_arg;
			end else if (fire) begin
				av_reg <= 1'b0;
			end
		end
	end

	assign act_valid = av_reg;
	assign act_code = ac_reg;
	assign act_arg = aa_reg;
	assign cmd_set = set_reg;

	// Fault tracking sees each feed once, when the consumer takes it
	dpcd_guard #(.HOLD_CYCLES(COVER_HOLD_CYCLES), .SENSORS(SENSORS)) u_guard (
		.clock(clock),
		.rst(rst),
		.cabinet_open(cabinet_open),
		.doc_covered(doc_covered),
		.doc_inserted(doc_inserted),
		.at_last_line(at_last_line),
		.feed_evt(fire && is_feed(ac_reg)),
		.eject_done(eject_done),
		.jam_clear(jam_clear),
		.print_en(print_en),
		.page_overflow(page_overflow),
		.eject_jam(eject_jam),
		.eject_req(eject_req),
		.cover_hold(cover_hold)
	);

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	a_sel_compat: assert property (take && st_reg == DPCD_ST_SEL &&
		b == DPCD_E_SEL_COMPAT && !keypad_sel |=> cmd_set == DPCD_SET_COMPAT
		&& act_valid && act_code == DPCD_A_SEL_COMPAT)
		else $error("compatible select not taken");
	a_esc_request: assert property (take && st_reg == DPCD_ST_ESC &&
		cmd_set == DPCD_SET_COMPAT && b == DPCD_B_STAT_NOW
		|=> act_code == DPCD_A_STAT_NOW)
		else $error("escaped status lost in compatible set");
	a_bare_status: assert property (take && st_reg == DPCD_ST_IDLE &&
		b == DPCD_B_STAT_DLY |=> act_code == (cmd_set == DPCD_SET_LEGACY ?
		DPCD_A_STAT_DLY : DPCD_A_CHAR))
		else $error("delayed status decode wrong");
	a_back_code: assert property (take && st_reg == DPCD_ST_IDLE &&
		b == DPCD_B_BACK && !keypad_sel |=> act_code ==
		(cmd_set == DPCD_SET_COMPAT ? DPCD_A_BACKSPACE : DPCD_A_REV_LINE))
		else $error("08 decode wrong");
	a_feed120: assert property (take && st_reg == DPCD_ST_ESC &&
		cmd_set == DPCD_SET_LEGACY && hi3 |=> act_code == DPCD_A_FEED120
		&& act_arg == {4'h0, $past(b[3:0])})
		else $error("legacy small feed wrong");
	a_feed216_arg: assert property (take && st_reg == DPCD_ST_ESC &&
		b == DPCD_E_FEED216 ##1 take [*1] |=> act_code == DPCD_A_FEED216 &&
		act_arg == $past(b))
		else $error("n/216 feed argument wrong");
	a_out_stable: assert property (act_valid && !act_ready |=>
		act_valid && $stable(act_code) && $stable(act_arg))
		else $error("action changed while stalled");
	// A held character must stay at the head of the queue, not be consumed
	a_print_held: assert property (!print_en && strm.valid &&
		st_reg == DPCD_ST_IDLE && ctl == DPCD_A_CHAR |=>
		strm.valid && $stable(b))
		else $error("character taken while printing held");
	c_mode_switch: cover property (act_valid && act_code == DPCD_A_SEL_COMPAT);
	c_spaces: cover property (act_valid && act_code == DPCD_A_SPACES);
	c_stall: cover property (act_valid && !act_ready [*2]);
endmodule // dpcd_decoder
`default_nettype wire

// ==== dv/dpcd_act_sink.sv ====
// Action consumer model standing at the decoder's output side
`timescale 1ns/1ns
`default_nettype none
module dpcd_act_sink import dpcd_pkg::*; (
	input wire logic clock,
	input wire logic rst,
	input wire logic hold,
	input wire logic act_valid,
	output logic act_ready,
	input wire dpcd_act_t act_code,
	input wire logic [7:0] act_arg,
	output logic [15:0] n_taken,
	output dpcd_act_t last_code,
	output logic [7:0] last_arg
);
	// Stalls for as long as the bench holds it, so back-pressure is real
	assign act_ready = !hold;
	// Capture each action on the edge that takes it
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			n_taken <= 16'h0000;
			last_code <= DPCD_A_NONE;
			last_arg <= 8'h00;
		end else if (act_valid && act_ready) begin
			n_taken <= n_taken + 16'h0001;
			last_code <= act_code;
			last_arg <= act_arg;
		end
	end
endmodule // dpcd_act_sink
`default_nettype wire

// ==== dv/tb.sv ====
// Self-checking bench for the printer command decoder
`timescale 1ns/1ns
`default_nettype none
module tb import dpcd_pkg::*; ;
	localparam logic [7:0] nb = 8'h00;
	logic clock = 0, rst = 1, in_valid = 0, hold = 0;
	logic keypad_sel = 0, keypad_compat = 0, cabinet_open = 0;
	logic doc_inserted = 0, at_last_line = 0, eject_done = 0;
	logic jam_clear = 0;
	logic [7:0] in_data = 8'h00;
	logic [3:0] doc_covered = 4'h0;
	logic in_ready, act_valid, act_ready, print_en, page_overflow;
	logic eject_jam, eject_req, cover_hold;
	logic [7:0] act_arg, last_arg;
	logic [15:0] n_taken;
	dpcd_act_t act_code, last_code;
	dpcd_set_t cmd_set;
	int fails = 0, checks_done = 0, cycles = 0, ejects = 0;

	dpcd_decoder #(.COVER_HOLD_CYCLES(20), .SENSORS(4)) dpcd_decoder_inst (
		.clock(clock), .rst(rst), .in_valid(in_valid),
		.in_ready(in_ready), .in_data(in_data),
		.keypad_sel(keypad_sel), .keypad_compat(keypad_compat),
		.act_valid(act_valid), .act_ready(act_ready),
		.act_code(act_code), .act_arg(act_arg), .cmd_set(cmd_set),
		.cabinet_open(cabinet_open), .doc_covered(doc_covered),
		.doc_inserted(doc_inserted), .at_last_line(at_last_line),
		.eject_done(eject_done), .jam_clear(jam_clear),
		.print_en(print_en), .page_overflow(page_overflow),
		.eject_jam(eject_jam), .eject_req(eject_req),
		.cover_hold(cover_hold));
	dpcd_act_sink dpcd_act_sink_inst (
		.clock(clock), .rst(rst), .hold(hold), .act_valid(act_valid),
		.act_ready(act_ready), .act_code(act_code), .act_arg(act_arg),
		.n_taken(n_taken), .last_code(last_code), .last_arg(last_arg));

	// 50 MHz clock
	always #10 clock = ~clock;

	// Hang guard and eject pulse count
	always @(posedge clock) begin
		cycles = cycles + 1;
		if (eject_req === 1'b1) ejects = ejects + 1;
		if (cycles == 20000) begin
			fails = fails + 1;
			final_report();
		end
	end

	task final_report();
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	task check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done = checks_done + 1;
		if (seen !== exp) begin
			fails = fails + 1;
			$display("wrong value at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Inputs always move 2 ns after the rising edge
	task tick(input int n);
		repeat (n) @(posedge clock);
		#2;
	endtask

	// Holds the byte until an edge samples in_ready high
	task send(input logic [7:0] b);
		in_valid = 1;
		in_data = b;
		while (in_ready !== 1'b1) tick(1);
		tick(1);
	endtask

	task wait_act(input logic [15:0] p);
		int k;
		k = 0;
		while (n_taken === p && k < 50) begin
			tick(1);
			k = k + 1;
		end
	endtask

	task cmd(input int n, input logic [7:0] b0, input logic [7:0] b1,
		input logic [7:0] b2, input dpcd_act_t c, input logic [7:0] a);
		logic [15:0] p;
		p = n_taken;
		send(b0);
		if (n > 1) send(b1);
		if (n > 2) send(b2);
		in_valid = 0;
		wait_act(p);
		check(16'(last_code), 16'(c));
		check(16'(last_arg), 16'(a));
	endtask

	// Escape select sequence, then the active set
	task sel(input logic [7:0] b, input dpcd_act_t c, input dpcd_set_t s);
		logic [15:0] p;
		p = n_taken;
		send(8'h1B);
		send(8'h7E);
		send(b);
		in_valid = 0;
		wait_act(p);
		check(16'(last_code), 16'(c));
		check(16'(cmd_set), 16'(s));
	endtask

	task t_legacy();
		cmd(1, 8'h05, nb, nb, DPCD_A_STAT_NOW, 8'h05);
		cmd(1, 8'h1A, nb, nb, DPCD_A_STAT_DLY, 8'h1A);
		cmd(1, 8'h07, nb, nb, DPCD_A_UPPER_NOW, 8'h07);
		cmd(1, 8'h13, nb, nb, DPCD_A_UPPER_DLY, 8'h13);
		cmd(1, 8'h17, nb, nb, DPCD_A_UPPER_DLY, 8'h17);
		cmd(1, 8'h1C, nb, nb, DPCD_A_LOWER_NOW, 8'h1C);
		cmd(1, 8'h1D, nb, nb, DPCD_A_LOWER_DLY, 8'h1D);
		cmd(1, 8'h08, nb, nb, DPCD_A_REV_LINE, 8'h08);
		cmd(2, 8'h09, 8'h5A, nb, DPCD_A_CFG_LOAD, 8'h5A);
		cmd(2, 8'h0B, 8'h63, nb, DPCD_A_VFEED, 8'h63);
		cmd(1, 8'h0F, nb, nb, DPCD_A_EXP_OFF, 8'h0F);
		cmd(1, 8'h12, nb, nb, DPCD_A_LCOUNT, 8'h12);
		cmd(1, 8'h11, nb, nb, DPCD_A_KEYBUF, 8'h11);
		cmd(1, 8'h10, nb, nb, DPCD_A_KEYBUF, 8'h10);
		cmd(1, 8'h18, nb, nb, DPCD_A_CHAR, 8'h18);
		cmd(1, 8'h19, nb, nb, DPCD_A_DOCLEN, 8'h19);
		cmd(2, 8'h1B, 8'h3F, nb, DPCD_A_FEED120, 8'h0F);
		cmd(3, 8'h1B, 8'h4A, 8'h80, DPCD_A_FEED216, 8'h80);
		cmd(2, 8'h1E, 8'h07, nb, DPCD_A_SPACES, 8'h07);
		cmd(1, 8'h41, nb, nb, DPCD_A_CHAR, 8'h41);
		cmd(1, 8'h0C, nb, nb, DPCD_A_EJECT, 8'h0C);
		cmd(1, 8'h0D, nb, nb, DPCD_A_PRINT, 8'h0D);
		cmd(1, 8'h0E, nb, nb, DPCD_A_EXP_ON, 8'h0E);
		cmd(3, 8'h1B, 8'h7E, 8'h41, DPCD_A_ESC_OTHER, 8'h41);
		cmd(1, 8'h14, nb, nb, DPCD_A_MRESET, 8'h14);
	endtask

	task t_compat();
		sel(8'h49, DPCD_A_SEL_COMPAT, DPCD_SET_COMPAT);
		cmd(1, 8'h08, nb, nb, DPCD_A_BACKSPACE, 8'h08);
		cmd(1, 8'h09, nb, nb, DPCD_A_HTAB, 8'h09);
		cmd(1, 8'h0B, nb, nb, DPCD_A_VTAB, 8'h0B);
		cmd(1, 8'h0F, nb, nb, DPCD_A_CPI17, 8'h0F);
		cmd(1, 8'h12, nb, nb, DPCD_A_CPI10, 8'h12);
		cmd(1, 8'h14, nb, nb, DPCD_A_EXP_OFF, 8'h14);
		cmd(1, 8'h18, nb, nb, DPCD_A_CLEAR, 8'h18);
		cmd(1, 8'h19, nb, nb, DPCD_A_CHAR, 8'h19);
		cmd(1, 8'h1E, nb, nb, DPCD_A_CHAR, 8'h1E);
		cmd(1, 8'h05, nb, nb, DPCD_A_CHAR, 8'h05);
		cmd(2, 8'h1B, 8'h05, nb, DPCD_A_STAT_NOW, 8'h05);
		cmd(2, 8'h1B, 8'h1A, nb, DPCD_A_STAT_DLY, 8'h1A);
		cmd(2, 8'h1B, 8'h17, nb, DPCD_A_UPPER_DLY, 8'h17);
		cmd(2, 8'h1B, 8'h1D, nb, DPCD_A_LOWER_DLY, 8'h1D);
		cmd(2, 8'h1B, 8'h10, nb, DPCD_A_KEYBUF, 8'h10);
		cmd(2, 8'h1B, 8'h3F, nb, DPCD_A_ESC_OTHER, 8'h3F);
		cmd(3, 8'h1B, 8'h4A, 8'h05, DPCD_A_FEED216, 8'h05);
		sel(8'h43, DPCD_A_SEL_LEGACY, DPCD_SET_LEGACY);
	endtask

	task t_keypad();
		keypad_sel = 1;
		keypad_compat = 1;
		tick(1);
		keypad_sel = 0;
		tick(1);
		check(16'(cmd_set), 16'(DPCD_SET_COMPAT));
		keypad_sel = 1;
		keypad_compat = 0;
		tick(1);
		keypad_sel = 0;
		tick(1);
		check(16'(cmd_set), 16'(DPCD_SET_LEGACY));
	endtask

	// Sink stalls for 8 cycles so the buffer refuses, then every word must arrive
	task t_buffer();
		int acc;
		logic [15:0] p;
		acc = 0;
		p = n_taken;
		hold = 1;
		in_valid = 1;
		in_data = 8'h42;
		repeat (8) begin
			if (in_ready === 1'b1) acc = acc + 1;
			tick(1);
		end
		in_valid = 0;
		check(16'(in_ready), 16'h0001 - 16'h0001);
		// Two buffer entries plus the one-deep action register
		check(16'(acc), 16'h0003);
		hold = 0;
		tick(10);
		check(n_taken, p + 16'(acc));
		check(16'(last_arg), 16'h0042);
	endtask

	task t_cover();
		logic [15:0] p;
		cabinet_open = 1;
		tick(1);
		check(16'(print_en), 16'h0000);
		check(16'(cover_hold), 16'h0001);
		p = n_taken;
		send(8'h43);
		in_valid = 0;
		tick(5);
		check(n_taken, p);
		cabinet_open = 0;
		tick(19);
		check(16'(print_en), 16'h0000);
		tick(1);
		check(16'(print_en), 16'h0001);
		tick(4);
		check(n_taken, p + 16'h0001);
	endtask

	task t_overflow();
		int e;
		e = ejects;
		at_last_line = 1;
		cmd(1, 8'h0A, nb, nb, DPCD_A_LINE, 8'h0A);
		tick(2);
		check(16'(page_overflow), 16'h0001);
		check(16'(ejects), 16'(e + 1));
		check(16'(print_en), 16'h0000);
		at_last_line = 0;
		doc_inserted = 1;
		tick(1);
		doc_inserted = 0;
		tick(2);
		check(16'(page_overflow), 16'h0000);
	endtask

	task t_jam();
		doc_covered = 4'h2;
		eject_done = 1;
		tick(1);
		eject_done = 0;
		tick(1);
		check(16'(eject_jam), 16'h0001);
		doc_covered = 4'h0;
		jam_clear = 1;
		tick(1);
		jam_clear = 0;
		tick(1);
		check(16'(eject_jam), 16'h0000);
		// A second reset with a covered sensor must come up jammed
		doc_covered = 4'h8;
		rst = 1;
		tick(2);
		rst = 0;
		tick(3);
		check(16'(eject_jam), 16'h0001);
	endtask

	// Main sequence: reset, then one task per scenario
	initial begin
		tick(20);
		check(16'(in_ready), 16'h0001);
		check(16'(act_valid), 16'h0000);
		check(16'(cmd_set), 16'(DPCD_RESET_SET));
		rst = 0;
		tick(3);
		check(16'(print_en), 16'h0001);
		t_legacy();
		t_compat();
		t_keypad();
		t_buffer();
		t_cover();
		t_overflow();
		t_jam();
		final_report();
	end
endmodule // tb
`default_nettype wire
